// File: design/cpd_decode.sv
// Purpose: decode and execute of signed add and saturating magnitude, compact packet checks
// Assumes: one 20 MHz clock, synchronous active-high reset, operands already read
// Notes: single-cycle execute; result registered one cycle after issue
// Function
// - spanning execute packet keeps both headers; each insn uses its own packet's header.
// - spanning packet accepted as interrupt return target when interrupt came just before.
// - compact insns only on allowed units; mpy on M, load/store on D, nop none.
// - crossable operand comes from opposite file when the x bit is set.
// - logic unit opfield 0x20 adds sign-extended five-bit constant to 40-bit source.
// - data unit opfield 0x12 adds zero-extended five-bit constant to 32-bit source.
// - signed-marked operands and constants are sign-extended to operation width.
// - add writes src1 plus src2 when condition holds, otherwise no operation.
// - saturating magnitude on logic units only, opfields 0x1a and 0x38, one cycle.
// - 32-bit magnitude passes positives, negates negatives, most negative saturates.
// - 40-bit magnitude likewise, most negative 40-bit value saturates to maximum.
// - packed variant takes magnitude of each 16-bit half independently.
`include "cpd_consts.svh"
`default_nettype none
module cpd_decode #(
    parameter int EP_MAX = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire cpd_pkg::cpd_hdr_t hdr_cur,
    input wire cpd_pkg::cpd_hdr_t hdr_next,
    input wire logic ep_spans,
    input wire logic [3:0] ep_count,
    input wire logic ep_is_branch_target,
    input wire logic int_taken_before_e1,
    input wire cpd_pkg::cpd_insn_t insn,
    input wire cpd_pkg::cpd_opnd_t opnd,
    input wire logic [5:0] pred_regs,
    output logic [31:0] active_hdr,
    output logic hdr_cur_on,
    output logic hdr_next_on,
    output logic return_target_ok,
    output logic wb_valid,
    output logic wb_side_b,
    output logic [4:0] wb_dst,
    output logic wb_wide,
    output logic [39:0] wb_data,
    output logic unit_err,
    output logic pack_err
);
    cpd_pkg::cpd_state_t st;
    cpd_pkg::cpd_state_t next_st;

    // -------------------------------------------------------------------
    // field extraction
    // -------------------------------------------------------------------
    logic [2:0] creg;
    logic zbit;
    logic xbit;
    logic [4:0] src1_f;
    logic [6:0] lop;
    logic [5:0] sop;
    logic [5:0] dop;
    logic cond_ok;
    cpd_pkg::cpd_op_t op;
    logic [39:0] s2;
    logic [31:0] s1;

    assign creg = insn.word[`CPD_CREG_HI:`CPD_CREG_LO];
    assign zbit = insn.word[`CPD_Z_BIT];
    assign xbit = insn.word[`CPD_X_BIT];
    assign src1_f = insn.word[`CPD_SRC1_HI:`CPD_SRC1_LO];
    assign lop = insn.word[11:5];
    assign sop = insn.word[11:6];
    assign dop = insn.word[12:7];

    // creg 000 means always with z clear, never with z set; codes map to the six predicate registers
    always_comb begin
        logic p;
        p = 1'b0;
        case (creg)
            3'h0: p = 1'b1;
            3'h1: p = pred_regs[0];
            3'h2: p = pred_regs[1];
            3'h3: p = pred_regs[2];
            3'h4: p = pred_regs[3];
            3'h5: p = pred_regs[4];
            3'h6: p = pred_regs[5];
            3'h7: p = 1'b0; // reserved code, reads as a zero register
            default: p = 1'b0;
        endcase
        if (creg == 3'h0) begin
            cond_ok = zbit ? 1'b0 : 1'b1;
        end else begin
            cond_ok = zbit ? ~p : p;
        end
    end

    // -------------------------------------------------------------------
    // opcode decode per unit
    // -------------------------------------------------------------------
    always_comb begin
        op = cpd_pkg::cpd_op_none;
        case (insn.unit)
            cpd_pkg::cpd_unit_l: begin
                if ((insn.word[17:2] & `CPD_L_PACKED_HALF_MAGNITUDE_MSK) == `CPD_L_PACKED_HALF_MAGNITUDE_PAT) begin
                    op = cpd_pkg::cpd_op_packed_half_magnitude;
                end else begin
                    case (lop)
                        `CPD_L_ADD_II, `CPD_L_ADD_CI: op = cpd_pkg::cpd_op_add32;
                        `CPD_L_ADD_IIL, `CPD_L_ADD_IL: op = cpd_pkg::cpd_op_add_long;
                        `CPD_L_ADD_CL: op = cpd_pkg::cpd_op_add_cst_long;
                        `CPD_L_ABS_I: op = cpd_pkg::cpd_op_abs32;
                        `CPD_L_ABS_L: op = cpd_pkg::cpd_op_abs40;
                        default: op = cpd_pkg::cpd_op_illegal;
                    endcase
                end
            end
            cpd_pkg::cpd_unit_s: begin
                case (sop)
                    `CPD_S_ADD_II, `CPD_S_ADD_CI: op = cpd_pkg::cpd_op_add32;
                    default: op = cpd_pkg::cpd_op_illegal;
                endcase
            end
            cpd_pkg::cpd_unit_d: begin
                case (dop)
                    `CPD_D_ADD_II: op = cpd_pkg::cpd_op_add32;
                    `CPD_D_ADD_UC: op = cpd_pkg::cpd_op_add_ucst;
                    default: op = cpd_pkg::cpd_op_illegal;
                endcase
            end
            default: op = cpd_pkg::cpd_op_illegal;
        endcase
    end

    // -------------------------------------------------------------------
    // operand selection
    // -------------------------------------------------------------------
    // long sources are never crossable; only the 32-bit ones obey the x bit
    logic s1_cross;
    logic s2_cross;
    logic s1_is_cst;
    always_comb begin
        s1_cross = 1'b0;
        s2_cross = 1'b0;
        s1_is_cst = 1'b0;
        case (op)
            cpd_pkg::cpd_op_add32: begin
                s1_is_cst = (insn.unit == cpd_pkg::cpd_unit_l) ? (lop == `CPD_L_ADD_CI)
                          : (insn.unit == cpd_pkg::cpd_unit_s) ? (sop == `CPD_S_ADD_CI) : 1'b0;
                s2_cross = (insn.unit != cpd_pkg::cpd_unit_d) & xbit;
            end
            cpd_pkg::cpd_op_add_long: begin
                s1_cross = (lop == `CPD_L_ADD_IL) & xbit;
                s2_cross = (lop == `CPD_L_ADD_IIL) & xbit;
            end
            cpd_pkg::cpd_op_add_cst_long: s1_is_cst = 1'b1;
            cpd_pkg::cpd_op_abs32, cpd_pkg::cpd_op_packed_half_magnitude: s2_cross = xbit;
            default: s1_is_cst = 1'b0;
        endcase
    end

    // signed constants sign-extend, the data-unit constant zero-extends
    always_comb begin
        logic [31:0] reg1;
        reg1 = s1_cross ? opnd.opp_src1 : opnd.own_src1;
        if (op == cpd_pkg::cpd_op_add_ucst) begin
            s1 = {27'h0, src1_f};
        end else if (s1_is_cst) begin
            s1 = {{27{src1_f[4]}}, src1_f};
        end else begin
            s1 = reg1;
        end
        s2 = s2_cross ? opnd.opp_src2 : opnd.own_src2;
    end

    // -------------------------------------------------------------------
    // execute
    // -------------------------------------------------------------------
    logic [39:0] result;
    logic wide_res;
    logic [15:0] half_mag [2];

    for (genvar h = 0; h < 2; h++) begin : g_half
        logic [15:0] hv;
        assign hv = s2[16*h +: 16];
        assign half_mag[h] = (hv == `CPD_MIN16) ? `CPD_MAX16 : (hv[15] ? 16'(-hv) : hv);
    end

    // 32-bit results leave [39:32] zero so the pair's high word stays clean
    always_comb begin
        logic [31:0] a32;
        logic [39:0] a40;
        a32 = s2[31:0];
        a40 = s2;
        result = 40'h0;
        wide_res = 1'b0;
        case (op)
            cpd_pkg::cpd_op_add32, cpd_pkg::cpd_op_add_ucst: begin
                result = {8'h0, s1 + a32};
            end
            cpd_pkg::cpd_op_add_long: begin
                wide_res = 1'b1;
                if (lop == `CPD_L_ADD_IIL) begin
                    result = {{8{s1[31]}}, s1} + {{8{a32[31]}}, a32};
                end else begin
                    result = {{8{s1[31]}}, s1} + a40;
                end
            end
            cpd_pkg::cpd_op_add_cst_long: begin
                wide_res = 1'b1;
                result = {{8{s1[31]}}, s1} + a40;
            end
            cpd_pkg::cpd_op_abs32: begin
                if (a32 == `CPD_MIN32) begin
                    result = {8'h0, `CPD_MAX32};
                end else begin
                    result = {8'h0, a32[31] ? 32'(-a32) : a32};
                end
            end
            cpd_pkg::cpd_op_abs40: begin
                wide_res = 1'b1;
                if (a40 == `CPD_MIN40) begin
                    result = `CPD_MAX40;
                end else begin
                    result = a40[39] ? 40'(-a40) : a40;
                end
            end
            cpd_pkg::cpd_op_packed_half_magnitude: result = {8'h0, half_mag[1], half_mag[0]};
            default: result = 40'h0;
        endcase
    end

    // -------------------------------------------------------------------
    // compact unit legality and packet checks
    // -------------------------------------------------------------------
    logic unit_bad;
    always_comb begin
        unit_bad = 1'b0;
        if (insn.valid && insn.compact) begin
            case (insn.cls)
                cpd_pkg::cpd_cls_mul: unit_bad = insn.unit != cpd_pkg::cpd_unit_m;
                cpd_pkg::cpd_cls_mem: unit_bad = insn.unit != cpd_pkg::cpd_unit_d;
                cpd_pkg::cpd_cls_nounit: unit_bad = insn.unit != cpd_pkg::cpd_unit_none;
                cpd_pkg::cpd_cls_alu: unit_bad = (insn.unit == cpd_pkg::cpd_unit_none)
                                              | (insn.unit == cpd_pkg::cpd_unit_m);
                default: unit_bad = 1'b1;
            endcase
        end
    end

    // the second header only counts while the packet really spans
    logic any_hdr;
    logic full_ep;
    assign any_hdr = hdr_cur.valid | (ep_spans & hdr_next.valid);
    assign full_ep = ep_count >= 4'(EP_MAX);

    // -------------------------------------------------------------------
    // state update
    // -------------------------------------------------------------------
    // checks are registered with the result so both land in the same cycle
    always_comb begin
        next_st = st;
        // hold both headers while the execute packet spans
        next_st.hdr0 = hdr_cur.valid ? hdr_cur.word : 32'h0;
        next_st.hdr0_on = hdr_cur.valid;
        next_st.hdr1 = (ep_spans & hdr_next.valid) ? hdr_next.word : 32'h0;
        next_st.hdr1_on = ep_spans & hdr_next.valid;
        // a spanning packet is only legal as a return point after an interrupt
        next_st.span_ok_ret = ep_spans & int_taken_before_e1;
        next_st.pack_err = (full_ep & any_hdr)
                         | (ep_is_branch_target & ep_spans & any_hdr & ~int_taken_before_e1);
        next_st.unit_err = unit_bad;
        next_st.wb.valid = insn.valid & cond_ok & ~unit_bad
                         & (op != cpd_pkg::cpd_op_none) & (op != cpd_pkg::cpd_op_illegal);
        next_st.wb.side_b = insn.word[`CPD_S_BIT];
        next_st.wb.dst = insn.word[`CPD_DST_HI:`CPD_DST_LO];
        next_st.wb.wide = wide_res;
        next_st.wb.data = result;
        if (rst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    // each instruction picks the header of the fetch packet that holds it
    assign active_hdr = insn.fp_sel ? st.hdr1 : st.hdr0;
    assign hdr_cur_on = st.hdr0_on;
    assign hdr_next_on = st.hdr1_on;
    assign return_target_ok = st.span_ok_ret;
    assign wb_valid = st.wb.valid;
    assign wb_side_b = st.wb.side_b;
    assign wb_dst = st.wb.dst;
    assign wb_wide = st.wb.wide;
    assign wb_data = st.wb.data;
    assign unit_err = st.unit_err;
    assign pack_err = st.pack_err;
endmodule
`default_nettype wire

// File: dv/cpd_decode_bench.sv
// Purpose: self-checking bench for cpd_decode
// Assumes: inputs change at falling edge, results one edge later
// Notes: data compared only when a write is expected
`default_nettype none
module cpd_decode_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic v; logic [39:0] d; logic ue; logic pe;
        logic ch; logic [33:0] h; logic cr; logic rt; logic lw;
    } cpd_note_t;
    localparam cpd_pkg::cpd_unit_t ul = cpd_pkg::cpd_unit_l;
    logic clk = 1'b0;
    logic rst = 1'b1;
    cpd_pkg::cpd_hdr_t hdr_cur = '0;
    cpd_pkg::cpd_hdr_t hdr_next = '0;
    logic ep_spans = 1'b0;
    logic [3:0] ep_count = 4'h1;
    logic ep_is_branch_target = 1'b0;
    logic int_taken_before_e1 = 1'b0;
    cpd_pkg::cpd_insn_t insn = '0;
    cpd_pkg::cpd_opnd_t opnd;
    logic [5:0] pred_regs = 6'h00;
    logic [31:0] active_hdr;
    logic hdr_cur_on, hdr_next_on, return_target_ok, wb_valid, wb_side_b, wb_wide, unit_err, pack_err;
    logic [4:0] wb_dst;
    logic [39:0] wb_data;
    logic [39:0] tb [3] = '{40'h8000000000, 40'h0080000000, 40'hffff684e3d};
    logic [31:0] lfsr = 32'h26da;
    int mismatches = 0;
    int num_checks = 0;
    cpd_note_t notes [$];
    cpd_note_t got;
    cpd_decode #(.EP_MAX(8)) u_cpd_decode (.*);
    cpd_regfile_model u_cpd_regfile_model (.*);
    always #25 clk = ~clk;
    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic logic [39:0] mag(input logic [39:0] v, input int w);
        logic [39:0] m;
        m = (40'h1 << w) - 40'h1;
        v = v & m;
        if (!v[w-1]) return v;
        if (v == (40'h1 << (w - 1))) return m >> 1;
        return (~v + 40'h1) & m;
    endfunction
    // lo carries x/opfield/format bits of the chosen unit
    function automatic logic [31:0] wd(input logic [3:0] cz, input logic [4:0] s1, input logic [12:0] lo);
        return {cz, 5'h03, 5'h02, s1, lo};
    endfunction
    function automatic cpd_pkg::cpd_insn_t mk(input logic [31:0] w, input cpd_pkg::cpd_unit_t u);
        mk = '0;
        mk.valid = 1'b1;
        mk.word = w;
        mk.unit = u;
    endfunction
    function automatic cpd_note_t note(input logic v, input logic [39:0] d);
        note = '0;
        note.v = v;
        note.d = d;
    endfunction
    // written result that fills the whole 40-bit pair
    function automatic cpd_note_t lnote(input logic [39:0] d);
        lnote = note(1'b1, d);
        lnote.lw = 1'b1;
    endfunction
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // wanted src2 operand goes where the x bit points, src1 to the own file; each inverse to the other file
    task automatic issue(input cpd_pkg::cpd_insn_t i, input logic [39:0] a, input logic [39:0] b, input cpd_note_t e);
        @(negedge clk);
        u_cpd_regfile_model.rf[i.word[1] ^ i.word[12]][i.word[22:18]] = a;
        u_cpd_regfile_model.rf[!(i.word[1] ^ i.word[12])][i.word[22:18]] = ~a;
        u_cpd_regfile_model.rf[i.word[1]][i.word[17:13]] = b;
        u_cpd_regfile_model.rf[!i.word[1]][i.word[17:13]] = ~b;
        insn = i;
        notes.push_back(e);
    endtask
    task automatic pkt(input logic [4:0] f, input logic [3:0] c, input logic pe, input logic rt, input logic fp);
        cpd_note_t e;
        cpd_pkg::cpd_insn_t i;
        @(negedge clk);
        hdr_cur = {f[4], 32'h0e2c4a01};
        hdr_next = {f[3], 32'h0f1d5b02};
        {ep_spans, ep_is_branch_target, int_taken_before_e1} = f[2:0];
        ep_count = c;
        e = note(1'b0, 40'h0);
        e.pe = pe;
        e.cr = 1'b1;
        e.rt = rt;
        e.ch = f[4] & f[3] & f[2];
        e.h = {2'b11, fp ? 32'h0f1d5b02 : 32'h0e2c4a01};
        i = mk(wd(4'h1, 5'h05, {1'b0, 7'h03, 5'h18}), ul);
        i.fp_sel = fp;
        issue(i, 40'h0, 40'h0, e);
    endtask
    // -------------------------------------------------------------------
    // result watcher and watchdog
    // -------------------------------------------------------------------
    always @(posedge clk) begin
        #1;
        if (notes.size() > 0) begin
            got = notes.pop_front();
            check(wb_valid, got.v);
            if (got.v) check(wb_data, got.d);
            if (got.v) check({wb_wide, wb_side_b, wb_dst}, {got.lw, 6'h03});
            check(unit_err, got.ue);
            check(pack_err, got.pe);
            if (got.ch) check({hdr_next_on, hdr_cur_on, active_hdr}, got.h);
            if (got.cr) check(return_target_ok, got.rt);
        end
    end
    initial begin
        #200000;
        mismatches++;
        print_verdict();
    end
    initial begin
        int i;
        logic [39:0] a, b, v, s;
        logic [31:0] r;
        logic [2:0] cr;
        cpd_pkg::cpd_insn_t q;
        cpd_note_t e;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(posedge clk);
        #1;
        check({active_hdr, hdr_cur_on, hdr_next_on, return_target_ok, wb_valid, unit_err, pack_err}, 40'h0);
        for (i = 0; i < 4; i++) begin
            r = rnd();
            v = i < 3 ? tb[i] : {r[7:0], rnd()};
            s = {8'h00, 16'(mag(v >> 16, 16)), 16'(mag(v, 16))};
            issue(mk(wd(4'h0, 5'h00, {i[0], 7'h1a, 5'h18}), ul), v, 40'h0, note(1'b1, mag(v, 32)));
            issue(mk(wd(4'h0, 5'h00, {1'b0, 7'h38, 5'h18}), ul), v, 40'h0, lnote(mag(v, 40)));
            issue(mk(wd(4'h0, 5'h04, {i[0], 7'h1a, 5'h18}), ul), v, 40'h0, note(1'b1, s));
        end
        for (i = 0; i < 4; i++) begin
            r = rnd();
            a = {r[7:0], rnd()};
            b = {8'h00, rnd()};
            s = {8'h00, a[31:0] + b[31:0]};
            v = {{8{b[31]}}, b[31:0]};
            issue(mk(wd(4'h0, 5'h05, {i[0], 7'h03, 5'h18}), ul), a, b, note(1'b1, s));
            issue(mk(wd(4'h0, 5'h05, {i[0], 6'h07, 6'h20}), cpd_pkg::cpd_unit_s), a, b, note(1'b1, s));
            issue(mk(wd(4'h0, 5'h13, {1'b0, 7'h20, 5'h18}), ul), a, b, lnote(a + 40'hfffffffff3));
            issue(mk(wd(4'h0, 5'h05, {i[0], 7'h23, 5'h18}), ul), a, b, lnote(v + {{8{a[31]}}, a[31:0]}));
            issue(mk(wd(4'h0, 5'h05, {1'b0, 7'h21, 5'h18}), ul), a, b, lnote(v + a));
            issue(mk(wd(4'h0, 5'h13, {i[0], 7'h02, 5'h18}), ul), a, b, note(1'b1, {8'h00, a[31:0] - 32'hd}));
            issue(mk(wd(4'h0, 5'h1a, {6'h12, 7'h40}), cpd_pkg::cpd_unit_d), a, b, note(1'b1, {8'h00, a[31:0] + 32'h1a}));
            issue(mk(wd(4'h0, 5'h05, {6'h10, 7'h40}), cpd_pkg::cpd_unit_d), a, b, note(1'b1, s));
        end
        // last add was creg 0, so the early predicate change cannot touch it
        @(negedge clk);
        pred_regs = 6'h29;
        for (i = 0; i < 20; i++) begin
            cr = i[3:1];
            q = mk(wd(i[3:0], 5'h05, {1'b1, 7'h03, 5'h18}), i != 19 ? ul : cpd_pkg::cpd_unit_m);
            q.compact = i > 15;
            q.cls = cpd_pkg::cpd_class_t'(i == 19 ? 2'h1 : i[1:0]);
            // creg 7 reads as a zero register, so its inverted sense writes
            e = note(i < 16 ? (cr == 3'h0 ? !i[0] : (cr != 3'h7 && pred_regs[cr - 3'h1]) ^ i[0]) : i == 16, s);
            e.ue = i inside {17, 18};
            issue(q, a, b, e);
        end
        pkt(5'b10110, 4'h3, 1'b1, 1'b0, 1'b0);
        pkt(5'b10111, 4'h3, 1'b0, 1'b1, 1'b0);
        pkt(5'b10000, 4'h8, 1'b1, 1'b0, 1'b0);
        pkt(5'b00100, 4'h8, 1'b0, 1'b0, 1'b0);
        pkt(5'b11100, 4'h3, 1'b0, 1'b0, 1'b0);
        pkt(5'b11100, 4'h3, 1'b0, 1'b0, 1'b1);
        @(negedge clk);
        insn.valid = 1'b0;
        repeat (3) @(posedge clk);
        print_verdict();
    end
endmodule
`default_nettype wire

// File: dv/cpd_monitor.sv
// Purpose: port checker for cpd_decode
// Assumes: bound into every cpd_decode instance
// Notes: abs checks on plain .L forms only, creg 0 z 0
`default_nettype none
module cpd_monitor #(
    parameter int EP_MAX = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire cpd_pkg::cpd_hdr_t hdr_cur,
    input wire cpd_pkg::cpd_hdr_t hdr_next,
    input wire logic ep_spans,
    input wire logic [3:0] ep_count,
    input wire logic ep_is_branch_target,
    input wire logic int_taken_before_e1,
    input wire cpd_pkg::cpd_insn_t insn,
    input wire cpd_pkg::cpd_opnd_t opnd,
    input wire logic [5:0] pred_regs,
    input wire logic hdr_cur_on,
    input wire logic hdr_next_on,
    input wire logic return_target_ok,
    input wire logic wb_valid,
    input wire logic [39:0] wb_data,
    input wire logic unit_err,
    input wire logic pack_err
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [31:0] w = insn.word;
    wire logic [2:0] cr = w[31:29];
    wire logic [39:0] src2v = w[12] ? opnd.opp_src2 : opnd.own_src2;
    wire logic plain = insn.valid && !insn.compact && insn.unit == cpd_pkg::cpd_unit_l && w[31:28] == 4'h0;
    wire logic abs32 = plain && w[17:13] == 5'h00 && w[11:2] == 10'h0d6;
    wire logic abs40 = plain && w[17:13] == 5'h00 && w[11:2] == 10'h1c6;
    wire logic pf = insn.valid && cr inside {[3'h1:3'h6]} && !w[28] && !pred_regs[cr - 3'h1];
    // -------------------------------------------------------------------
    // properties
    // -------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_abs32_sat: assert property (abs32 && src2v[31:0] == 32'h80000000 |=> wb_valid && wb_data == 40'h7fffffff)
        else $error("abs32 most negative not saturated");
    a_abs32_pass: assert property (abs32 && !src2v[31] |=> wb_data == {8'h00, $past(src2v[31:0])})
        else $error("abs32 positive altered");
    a_abs40_sat: assert property (abs40 && opnd.own_src2 == 40'h8000000000 |=> wb_valid && wb_data == 40'h7fffffffff)
        else $error("abs40 most negative not saturated");
    a_pred_false: assert property (pf |=> !wb_valid)
        else $error("write despite false predicate");
    a_wb_cause: assert property (wb_valid |-> $past(insn.valid))
        else $error("result without instruction");
    a_mul_unit: assert property (insn.valid && insn.compact && insn.cls == cpd_pkg::cpd_cls_mul
        && insn.unit != cpd_pkg::cpd_unit_m |=> unit_err && !wb_valid)
        else $error("compact multiply off its unit");
    a_hdr_both: assert property (ep_spans && hdr_cur.valid && hdr_next.valid |=> hdr_cur_on && hdr_next_on)
        else $error("spanning headers not both held");
    a_eight_err: assert property (ep_count >= EP_MAX && hdr_cur.valid |=> pack_err)
        else $error("full packet with header not flagged");
    a_branch_err: assert property (ep_spans && ep_is_branch_target && !int_taken_before_e1 && hdr_cur.valid
        |=> pack_err)
        else $error("spanning branch target not flagged");
    a_ret_ok: assert property (ep_spans && ep_is_branch_target && int_taken_before_e1 && ep_count < EP_MAX
        |=> return_target_ok && !pack_err)
        else $error("interrupt return target refused");
    cover property (abs32 && src2v[31:0] == 32'h80000000);
    cover property (pf);
    cover property (ep_spans && ep_is_branch_target && int_taken_before_e1);
endmodule
bind cpd_decode cpd_monitor #(.EP_MAX(EP_MAX)) u_cpd_monitor (.*);
`default_nettype wire

// File: dv/cpd_regfile_model.sv
// Purpose: operand read stage in front of cpd_decode
// Assumes: bench loads rf directly before each issue
// Notes: unloaded entries hold a toggling pattern, never a copy
`default_nettype none
module cpd_regfile_model (
    input wire cpd_pkg::cpd_insn_t insn,
    output var cpd_pkg::cpd_opnd_t opnd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [39:0] rf [2][32];
    wire logic s = insn.word[1];
    initial foreach (rf[j, k]) rf[j][k] = {20{2'b10}};
    // own file follows the s bit, opposite file the other side
    assign opnd.own_src2 = rf[s][insn.word[22:18]];
    assign opnd.opp_src2 = rf[!s][insn.word[22:18]];
    assign opnd.own_src1 = rf[s][insn.word[17:13]][31:0];
    assign opnd.opp_src1 = rf[!s][insn.word[17:13]][31:0];
endmodule
`default_nettype wire

// File: include/cpd_consts.svh
// Purpose: constants for the compact packet and add/abs decode block
// Assumes: included by the design file
// Notes: opfields and field positions of the 32-bit opcode, plus value limits
`ifndef CPD_CONSTS_SVH
`define CPD_CONSTS_SVH

// -------------------------------------------------------------------
// opcode field positions
// -------------------------------------------------------------------
`define CPD_CREG_HI 31
`define CPD_CREG_LO 29
`define CPD_Z_BIT 28
`define CPD_DST_HI 27
`define CPD_DST_LO 23
`define CPD_SRC2_HI 22
`define CPD_SRC2_LO 18
`define CPD_SRC1_HI 17
`define CPD_SRC1_LO 13
`define CPD_X_BIT 12
`define CPD_S_BIT 1

// -------------------------------------------------------------------
// opfields
// -------------------------------------------------------------------
`define CPD_L_ADD_II 7'h03
`define CPD_L_ADD_IIL 7'h23
`define CPD_L_ADD_IL 7'h21
`define CPD_L_ADD_CI 7'h02
`define CPD_L_ADD_CL 7'h20
`define CPD_L_ABS_I 7'h1a
`define CPD_L_ABS_L 7'h38
`define CPD_S_ADD_II 6'h07
`define CPD_S_ADD_CI 6'h06
`define CPD_D_ADD_II 6'h10
`define CPD_D_ADD_UC 6'h12
// packed magnitude: bits 17..2 fixed pattern with x bit masked out
`define CPD_L_PACKED_HALF_MAGNITUDE_PAT 16'h20d6
`define CPD_L_PACKED_HALF_MAGNITUDE_MSK 16'hfbff

// -------------------------------------------------------------------
// widths and limits
// -------------------------------------------------------------------
`define CPD_MAX32 32'h7fffffff
`define CPD_MIN32 32'h80000000
`define CPD_MAX40 40'h7fffffffff
`define CPD_MIN40 40'h8000000000
`define CPD_MAX16 16'h7fff
`define CPD_MIN16 16'h8000
`define CPD_MAX_EP_INSNS 4'h8

`endif

// File: include/cpd_pkg.sv
// Purpose: types for the compact packet and add/abs decode block
// Assumes: nothing
// Notes: types only; numbers live in cpd_consts.svh
`default_nettype none
package cpd_pkg;
    typedef enum logic [2:0] {
        cpd_unit_none,
        cpd_unit_l,
        cpd_unit_s,
        cpd_unit_m,
        cpd_unit_d
    } cpd_unit_t;

    typedef enum logic [3:0] {
        cpd_op_none,
        cpd_op_add32,
        cpd_op_add_long,
        cpd_op_add_cst_long,
        cpd_op_add_ucst,
        cpd_op_abs32,
        cpd_op_abs40,
        cpd_op_packed_half_magnitude,
        cpd_op_illegal
    } cpd_op_t;

    typedef enum logic [1:0] {
        cpd_cls_alu,
        cpd_cls_mul,
        cpd_cls_mem,
        cpd_cls_nounit
    } cpd_class_t;

    // one instruction as presented by fetch
    typedef struct packed {
        logic valid;
        logic [31:0] word;
        logic compact;
        cpd_class_t cls;
        cpd_unit_t unit;
        logic fp_sel;
    } cpd_insn_t;

    // header word of a compact fetch packet
    typedef struct packed {
        logic valid;
        logic [31:0] word;
    } cpd_hdr_t;

    // operands read from the register files
    typedef struct packed {
        logic [39:0] own_src2;
        logic [39:0] opp_src2;
        logic [31:0] own_src1;
        logic [31:0] opp_src1;
    } cpd_opnd_t;

    typedef struct packed {
        logic valid;
        logic side_b;
        logic [4:0] dst;
        logic wide;
        logic [39:0] data;
    } cpd_wb_t;

    typedef struct packed {
        logic [31:0] hdr0;
        logic [31:0] hdr1;
        logic hdr0_on;
        logic hdr1_on;
        logic span_ok_ret;
        cpd_wb_t wb;
        logic unit_err;
        logic pack_err;
    } cpd_state_t;
endpackage
`default_nettype wire
